// ### src/shelf_status_params.svh
// Constants for the shelf status signalling block.
// Assumes a 20 MHz core clock; included by the package and the modules.
`ifndef SHELF_STATUS_PARAMS_SVH
`define SHELF_STATUS_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CORE_CLK_HZ 20000000
`define TICK_HZ 1000
`define BACKUP_WARN_S 45
`define TICK_DIV (`CORE_CLK_HZ / `TICK_HZ)
`define BACKUP_WARN_TICKS (`BACKUP_WARN_S * `TICK_HZ)

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define TICK_CNT_W 15
`define WARN_CNT_W 16
`define SYNC_W 4
`define CNT_ZERO_TICK 15'h0000
`define CNT_ZERO_WARN 16'h0000

`endif

// ### src/shelf_status_pkg.sv
// Types for the shelf status signalling block.
// Assumes the params header sits beside it.
`include "shelf_status_params.svh"

package shelf_status_pkg;

   // ----------------------------------------------------------------------
   // Backup warning states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_ON_AC = 2'b00,
      ST_BACKUP = 2'b01,
      ST_WARN = 2'b10
   } backup_state_e;

endpackage

// ### src/shelf_status_signalling.sv
// Discrete status and presence signalling of a shelf power supply.
// Assumes inputs synchronous to CORE_CLK; open-collector pins are resolved
// outside from the enables (enable high pulls the wire low).
`timescale 1ns/10ps
`default_nettype none
`include "shelf_status_params.svh"

module shelf_status_signalling
   import shelf_status_pkg::*;
#(
   parameter int WARN_TICKS = `BACKUP_WARN_TICKS,
   parameter int TICK_DIV = `TICK_DIV
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic AC_PRESENT,
   input wire logic ON_BATTERY,
   input wire logic SELF_FAULT,
   input wire logic PEER_UNIT_FAULT,
   input wire logic PEER_UNIT_ABSENT,
   input wire logic BATTERY_FAIL_IN,
   input wire logic BATTERY_SLEEP_IN,
   input wire logic BATTERY_PRESENT_N,
   input wire logic BATTERY_PROTECT_IN,
   input wire logic BATTERY_STOP_DISCHARGE_IN,
   output logic POWER_LOSS_WARNING_N_O,
   output logic POWER_LOSS_WARNING_N_OE,
   output logic REDUNDANCY_LOST_N_O,
   output logic REDUNDANCY_LOST_N_OE,
   output logic SUPPLY_PRESENT_TO_BATTERY_N,
   output logic BATTERY_FEED_ENABLE,
   output logic BATTERY_FITTED,
   output logic BACKUP_WARNING
);

   // ----------------------------------------------------------------------
   // Millisecond tick
   // ----------------------------------------------------------------------
   logic tick;

   tick_divider #(
      .DIV(TICK_DIV)
   ) u_tick (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .tick(tick)
   );

   // ----------------------------------------------------------------------
   // Backup timer
   // ----------------------------------------------------------------------
   backup_state_e state;
   backup_state_e next_state;
   logic [`WARN_CNT_W-1:0] elapsed;
   logic [`WARN_CNT_W-1:0] next_elapsed;
   logic backup_active;

   // Backup only counts while on battery and AC is still missing
   assign backup_active = ON_BATTERY && !AC_PRESENT;

   // Count in ms ticks; coarse tick keeps the counter narrow
   always_comb begin
      next_state = state;
      next_elapsed = elapsed;
      case (state)
         ST_ON_AC: begin
            next_elapsed = `CNT_ZERO_WARN;
            if (backup_active) begin
               next_state = ST_BACKUP;
            end
         end
         ST_BACKUP: begin
            if (!backup_active) begin
               next_state = ST_ON_AC;
               next_elapsed = `CNT_ZERO_WARN;
            end else if (tick) begin
               if (elapsed == `WARN_CNT_W'(WARN_TICKS - 1)) begin
                  next_state = ST_WARN;
               end
               next_elapsed = elapsed + `WARN_CNT_W'(1);
            end
         end
         ST_WARN: begin
            if (!backup_active) begin
               next_state = ST_ON_AC;
               next_elapsed = `CNT_ZERO_WARN;
            end
         end
         default: begin
            next_state = ST_ON_AC;
            next_elapsed = `CNT_ZERO_WARN;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_ON_AC;
         elapsed <= `CNT_ZERO_WARN;
      end else begin
         state <= next_state;
         elapsed <= next_elapsed;
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   logic warn;
   logic redundancy_lost_n;
   logic fitted;
   logic feed_en;
   logic next_warn;
   logic next_redundancy_lost_n;
   logic next_fitted;
   logic next_feed_en;

   // Protection and stop-discharge are deliberately not in the OR term
   always_comb begin
      next_warn = (next_state == ST_WARN);
      next_fitted = !BATTERY_PRESENT_N;
      next_redundancy_lost_n = SELF_FAULT || PEER_UNIT_FAULT || PEER_UNIT_ABSENT
         || BATTERY_FAIL_IN || BATTERY_SLEEP_IN
         || BATTERY_PRESENT_N;
      next_feed_en = !BATTERY_PROTECT_IN;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         warn <= 1'b0;
         redundancy_lost_n <= 1'b0;
         fitted <= 1'b0;
         feed_en <= 1'b0;
      end else begin
         warn <= next_warn;
         redundancy_lost_n <= next_redundancy_lost_n;
         fitted <= next_fitted;
         feed_en <= next_feed_en;
      end
   end

   // ----------------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------------
   // Open collector: output level is always low, enable pulls the wire
   assign POWER_LOSS_WARNING_N_O = 1'b0;
   assign POWER_LOSS_WARNING_N_OE = warn;
   assign REDUNDANCY_LOST_N_O = 1'b0;
   assign REDUNDANCY_LOST_N_OE = redundancy_lost_n;
   // Tied low so the battery unit sees a supply fitted
   assign SUPPLY_PRESENT_TO_BATTERY_N = 1'b0;
   // Combinational path so protection cuts the feed without a clock edge
   assign BATTERY_FEED_ENABLE = feed_en && !BATTERY_PROTECT_IN;
   assign BATTERY_FITTED = fitted;
   assign BACKUP_WARNING = warn;

endmodule
`default_nettype wire

// ### src/tick_divider.sv
// Divides the core clock into a one-cycle enable pulse.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "shelf_status_params.svh"

module tick_divider
   import shelf_status_pkg::*;
#(
   parameter int DIV = `TICK_DIV
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);

   logic [`TICK_CNT_W-1:0] count;
   logic [`TICK_CNT_W-1:0] next_count;
   logic next_tick;

   // Wrap at DIV-1, pulse for one cycle on wrap
   always_comb begin
      if (count == `TICK_CNT_W'(DIV - 1)) begin
         next_count = `CNT_ZERO_TICK;
         next_tick = 1'b1;
      end else begin
         next_count = count + `TICK_CNT_W'(1);
         next_tick = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `CNT_ZERO_TICK;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end

endmodule
`default_nettype wire

// ### test/shelf_partner.sv
// Shelf and battery unit side: pull-ups on the alarm wires, present pin.
// Assumes enable high means the block pulls the wire low.
`timescale 1ns/10ps
`default_nettype none
module shelf_partner (
   input wire logic warn_oe,
   input wire logic warn_o,
   input wire logic red_oe,
   input wire logic red_o,
   input wire logic fit,
   output logic warn_wire,
   output logic red_wire,
   output logic present_n
);
   // Released wires rest high through the shelf pull-ups
   assign warn_wire = warn_oe ? warn_o : 1'b1;
   assign red_wire = red_oe ? red_o : 1'b1;
   assign present_n = fit ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### test/shelf_status_properties.sv
// Checker for the shelf status block, watching top ports only.
// Assumes WARN_TICKS=5 and TICK_DIV=4 in the bound instance.
`timescale 1ns/10ps
`default_nettype none
module shelf_status_properties (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic AC_PRESENT,
   input wire logic ON_BATTERY,
   input wire logic SELF_FAULT,
   input wire logic PEER_UNIT_FAULT,
   input wire logic PEER_UNIT_ABSENT,
   input wire logic BATTERY_FAIL_IN,
   input wire logic BATTERY_SLEEP_IN,
   input wire logic BATTERY_PRESENT_N,
   input wire logic BATTERY_PROTECT_IN,
   input wire logic BATTERY_STOP_DISCHARGE_IN,
   input wire logic POWER_LOSS_WARNING_N_O,
   input wire logic POWER_LOSS_WARNING_N_OE,
   input wire logic REDUNDANCY_LOST_N_O,
   input wire logic REDUNDANCY_LOST_N_OE,
   input wire logic SUPPLY_PRESENT_TO_BATTERY_N,
   input wire logic BATTERY_FEED_ENABLE,
   input wire logic BATTERY_FITTED,
   input wire logic BACKUP_WARNING
);
   logic [5:0] run;
   logic bk;
   logic flt;
   assign bk = ON_BATTERY && !AC_PRESENT;
   assign flt = SELF_FAULT || PEER_UNIT_FAULT || PEER_UNIT_ABSENT ||
      BATTERY_FAIL_IN || BATTERY_SLEEP_IN || BATTERY_PRESENT_N;
   // Saturating count of cycles spent on backup
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) run <= 6'h00;
      else run <= !bk ? 6'h00 : (run == 6'h3f ? run : run + 6'h01);
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   a_warn_late: assert property (run == 6'h1e |-> POWER_LOSS_WARNING_N_OE)
      else $error("warning missing after backup span");
   a_warn_early: assert property ($rose(POWER_LOSS_WARNING_N_OE) |-> run >= 6'h0c)
      else $error("warning came too early");
   a_warn_release: assert property (!bk |=> !POWER_LOSS_WARNING_N_OE)
      else $error("warning held after backup ended");
   a_warn_pin: assert property (BACKUP_WARNING == POWER_LOSS_WARNING_N_OE && !POWER_LOSS_WARNING_N_O)
      else $error("warning pin form wrong");
   a_red_set: assert property (flt |=> REDUNDANCY_LOST_N_OE && !REDUNDANCY_LOST_N_O)
      else $error("redundancy flag missing");
   a_red_clear: assert property (!flt |=> !REDUNDANCY_LOST_N_OE)
      else $error("redundancy flag without cause");
   a_fitted_follow: assert property (1'b1 |=> BATTERY_FITTED == !$past(BATTERY_PRESENT_N))
      else $error("fitted flag wrong");
   a_supply_ground: assert property (!SUPPLY_PRESENT_TO_BATTERY_N)
      else $error("supply present line not grounded");
   a_feed_cut: assert property (BATTERY_PROTECT_IN |-> !BATTERY_FEED_ENABLE)
      else $error("feed on during protection");
   c_warn: cover property ($rose(POWER_LOSS_WARNING_N_OE));
   c_red: cover property ($rose(REDUNDANCY_LOST_N_OE));
   c_prot: cover property (BATTERY_PROTECT_IN && BATTERY_STOP_DISCHARGE_IN);
endmodule
`default_nettype wire

// ### test/test_shelf_status_signalling.sv
// Bench for the shelf status block with short timing parameters.
// Assumes the partner model resolves the open-collector wires.
`timescale 1ns/10ps
`default_nettype none
module test_shelf_status_signalling;
   logic clk = 1'b0, rst_n = 1'b0, ac = 1'b1, onb = 1'b0, prot = 1'b0;
   logic stp = 1'b0, fit = 1'b1;
   logic [4:0] f = 5'h00;
   logic woe, wo, roe, ro, sp, feed, fitted, bw, ww, rw, pn;
   int bad_count = 0, comparisons = 0, n;
   always #25 clk = ~clk;
   shelf_partner par (.warn_oe(woe), .warn_o(wo), .red_oe(roe), .red_o(ro),
      .fit(fit), .warn_wire(ww), .red_wire(rw), .present_n(pn));
   shelf_status_signalling #(.WARN_TICKS(5), .TICK_DIV(4)) uut (
      .CORE_CLK(clk), .RST_N(rst_n), .AC_PRESENT(ac), .ON_BATTERY(onb),
      .SELF_FAULT(f[0]), .PEER_UNIT_FAULT(f[1]), .PEER_UNIT_ABSENT(f[2]),
      .BATTERY_FAIL_IN(f[3]), .BATTERY_SLEEP_IN(f[4]),
      .BATTERY_PRESENT_N(pn), .BATTERY_PROTECT_IN(prot),
      .BATTERY_STOP_DISCHARGE_IN(stp), .POWER_LOSS_WARNING_N_O(wo),
      .POWER_LOSS_WARNING_N_OE(woe), .REDUNDANCY_LOST_N_O(ro),
      .REDUNDANCY_LOST_N_OE(roe), .SUPPLY_PRESENT_TO_BATTERY_N(sp),
      .BATTERY_FEED_ENABLE(feed), .BATTERY_FITTED(fitted),
      .BACKUP_WARNING(bw));
   task chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task tk(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Backup span, then AC returns
   task t_warn;
      onb = 1'b1; ac = 1'b0; n = 0;
      while (ww !== 1'b0 && n < 40) begin tk(1); n++; end
      chk(n >= 12 && n <= 30 && bw === 1'b1, "warning timing");
      ac = 1'b1; tk(2);
      chk(ww === 1'b1 && bw === 1'b0, "warning kept");
      onb = 1'b0; $display("t_warn done");
   endtask
   // Each loss source alone, then battery removed
   task t_red;
      for (int i = 0; i < 6; i++) begin
         if (i < 5) f[i] = 1'b1; else fit = 1'b0;
         tk(2); chk(rw === 1'b0, "redundancy not flagged");
         chk(i < 5 || fitted === 1'b0, "fitted flag kept");
         f = 5'h00; fit = 1'b1; tk(2);
         chk(rw === 1'b1 && fitted === 1'b1, "redundancy stuck");
      end
      $display("t_red done");
   endtask
   // Protection and stop discharge must not raise the flag
   task t_prot;
      prot = 1'b1; stp = 1'b1; #1;
      chk(feed === 1'b0, "feed still on");
      tk(3); chk(rw === 1'b1 && sp === 1'b0, "flag on protection");
      prot = 1'b0; stp = 1'b0; tk(2);
      chk(feed === 1'b1, "feed not restored");
      $display("t_prot done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tk(4); rst_n = 1'b1; tk(2);
      chk(ww === 1'b1 && rw === 1'b1, "pins not released");
      t_warn; t_red; t_prot; summarize;
   end
   // Run needs about 60 cycles
   initial begin
      #(5000 * 50); bad_count++; summarize;
   end
endmodule
bind shelf_status_signalling shelf_status_properties chk_i (.*);
`default_nettype wire
